/* nia_defines.svh */
// nia_defines.svh: offsets, field positions, reset values and widths for
// the nested interrupt acceptance block.
// assumes: included by bare name; definitions only.
`ifndef NIA_DEFINES_SVH
`define NIA_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define NIA_OFS_REQ      8'h00
`define NIA_OFS_BLOCK    8'h04
`define NIA_OFS_URGENCY  8'h08
`define NIA_OFS_STATE    8'h0c

// ----------------------------------------------------------------------
// state register fields and reset values
// ----------------------------------------------------------------------
`define NIA_STATE_ENABLE_BIT 0
`define NIA_STATE_LEVEL_BIT  1
`define NIA_RST_ENABLE       1'b0
`define NIA_RST_LEVEL        1'b1
`define NIA_RST_REQ_BIT      1'b0
`define NIA_RST_BLOCK_BIT    1'b1
`define NIA_RST_URGENCY_BIT  1'b1

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define NIA_APB_AW           8
`define NIA_APB_DW           32
`define NIA_NUM_SRC          8

`endif

/* nia_pkg.sv */
// nia_pkg.sv: types shared by the nested interrupt acceptance block.
// assumes: nia_defines.svh holds every number.
package nia_pkg;

  // ----------------------------------------------------------------------
  // status word carried to the core for stacking
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic global_accept_enable;
    logic current_service_level;
  } nia_state_t;

  // ----------------------------------------------------------------------
  // instruction boundary report from the core
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic instr_end;
    logic hold_class;
    logic software_trap_instruction;
    logic accept_on_instruction;
    logic accept_off_instruction;
    logic return_op;
  } nia_instr_t;

endpackage

/* nia_accept.sv */
// nia_accept.sv: nested interrupt acceptance decision beside an 8-bit core.
// assumes: core reports each instruction end on the same clock; sources
// pulse on the same clock; software reaches the flags over APB.
`include "nia_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - no maskable acceptance unless global_accept_enable is 1
// - any acceptance clears global_accept_enable
// - nesting arbitrates on programmed urgency bits, not the default order
// - enabled: equal or higher urgency than the serviced one is accepted
// - lower urgency than the serviced one is refused while servicing
// - refused requests stay pending; one main instruction runs after return
// - service level 0: only urgency bit 0 requests accepted
// - service level 1: both urgency levels accepted when enabled
// - during trap service both levels accepted; trap always accepted
// - urgency bit 0 is high level, 1 is low level
// - after a hold-class instruction, acceptance waits one more instruction
// - status word, enable/disable and both return ops are hold-class
// - writes to request, block or urgency flags are hold-class too
// - trap is not hold-class; a maskable request at the trap waits
// - request capture ignores urgency bits
// - eligible: request 1 and block 0; acceptance also needs enable 1
// - higher urgency wins; ties go to the lowest source index
// - accept: stack status word, clear enable, copy urgency to service level
module nia_accept #(
  parameter int NUM_SRC = `NIA_NUM_SRC
) (
  // clock and reset
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     ARST_N_I,
  // apb slave
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [`NIA_APB_AW-1:0]   PADDR_I,
  input  wire logic [`NIA_APB_DW-1:0]   PWDATA_I,
  output logic      [`NIA_APB_DW-1:0]   PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  // core side
  input  wire nia_pkg::nia_instr_t      INSTR_I,
  input  wire nia_pkg::nia_state_t      RESTORE_STATE_I,
  input  wire logic [NUM_SRC-1:0]       SRC_REQ_I,
  // acceptance result
  output logic                          ACCEPT_O,
  output logic                          ACCEPT_SOFT_O,
  output logic [$clog2(NUM_SRC)-1:0]    ACCEPT_SRC_O,
  output nia_pkg::nia_state_t           STACK_STATE_O,
  output nia_pkg::nia_state_t           STATE_O
);

  localparam int IW = $clog2(NUM_SRC);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [NUM_SRC-1:0] pending_request_bit_r;
  logic [NUM_SRC-1:0] source_block_bit_r;
  logic [NUM_SRC-1:0] urgency_select_bit_r;
  logic               global_accept_enable_r;
  logic               current_service_level_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [31:0]        prdata_r;

  // first set bit from index 0, the fixed default order
  function automatic logic [IW-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IW'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic setup_c;
  logic wr_c;
  logic hit_req_c;
  logic hit_blk_c;
  logic hit_urg_c;
  logic hit_st_c;
  logic flag_touch_c;
  logic [31:0] rd_c;

  assign setup_c = PSEL_I && !PENABLE_I;
  assign wr_c    = PSEL_I && PENABLE_I && pready_r && PWRITE_I && !pslverr_r;

  // address decode and read mux; read data and error are sampled in the setup cycle, writes use the decode in the access cycle
  always_comb begin
    hit_req_c = 1'b0;
    hit_blk_c = 1'b0;
    hit_urg_c = 1'b0;
    hit_st_c  = 1'b0;
    rd_c      = '0;
    if (PADDR_I == `NIA_OFS_REQ) begin
      hit_req_c = 1'b1;
      rd_c      = 32'(pending_request_bit_r);
    end else if (PADDR_I == `NIA_OFS_BLOCK) begin
      hit_blk_c = 1'b1;
      rd_c      = 32'(source_block_bit_r);
    end else if (PADDR_I == `NIA_OFS_URGENCY) begin
      hit_urg_c = 1'b1;
      rd_c      = 32'(urgency_select_bit_r);
    end else if (PADDR_I == `NIA_OFS_STATE) begin
      hit_st_c  = 1'b1;
      rd_c[`NIA_STATE_ENABLE_BIT] = global_accept_enable_r;
      rd_c[`NIA_STATE_LEVEL_BIT]  = current_service_level_r;
    end
  end

  // flag registers touched by software defer acceptance like a status op
  assign flag_touch_c = wr_c && (hit_req_c || hit_blk_c || hit_urg_c);

  // one access cycle: ready rises in the first access cycle
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup_c;
      pslverr_r <= setup_c && !(hit_req_c || hit_blk_c || hit_urg_c || hit_st_c);
      if (setup_c) begin
        prdata_r <= rd_c;
      end
    end
  end

  assign PREADY_O  = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign PRDATA_O  = prdata_r;

  // ----------------------------------------------------------------------
  // acceptance decision
  // ----------------------------------------------------------------------
  logic [NUM_SRC-1:0] eligible_c;
  logic [NUM_SRC-1:0] high_c;
  logic [NUM_SRC-1:0] cand_c;
  logic               boundary_c;
  logic               trap_c;
  logic               take_c;
  logic [IW-1:0]      win_c;

  assign eligible_c = pending_request_bit_r & ~source_block_bit_r;
  assign high_c     = eligible_c & ~urgency_select_bit_r;
  // level 0 admits only high urgency; level 1 admits both
  assign cand_c     = current_service_level_r ? eligible_c : high_c;
  // a hold-class end or a flag write blocks this boundary
  assign boundary_c = INSTR_I.instr_end && !INSTR_I.hold_class && !flag_touch_c;
  assign trap_c     = INSTR_I.instr_end && INSTR_I.software_trap_instruction;
  // trap takes the boundary, so a maskable request waits behind it
  assign take_c     = boundary_c && !trap_c && global_accept_enable_r
                      && (cand_c != '0);
  // high urgency first, then default order within it
  assign win_c      = (high_c != '0) ? first_set(high_c) : first_set(cand_c);

  // ----------------------------------------------------------------------
  // pending request flags: source set wins over any clear
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pending_request_bit_r <= {NUM_SRC{`NIA_RST_REQ_BIT}};
    end else begin
      logic [NUM_SRC-1:0] nxt;
      nxt = pending_request_bit_r;
      if (wr_c && hit_req_c) begin
        nxt = PWDATA_I[NUM_SRC-1:0];
      end
      if (take_c) begin
        nxt[win_c] = 1'b0;
      end
      // capture ignores urgency; refused ones simply remain set
      pending_request_bit_r <= nxt | SRC_REQ_I;
    end
  end

  // block and urgency flags, software only
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      source_block_bit_r   <= {NUM_SRC{`NIA_RST_BLOCK_BIT}};
      urgency_select_bit_r <= {NUM_SRC{`NIA_RST_URGENCY_BIT}};
    end else begin
      if (wr_c && hit_blk_c) begin
        source_block_bit_r <= PWDATA_I[NUM_SRC-1:0];
      end
      if (wr_c && hit_urg_c) begin
        urgency_select_bit_r <= PWDATA_I[NUM_SRC-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // global enable and service level
  // ----------------------------------------------------------------------
  // acceptance beats every other update in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      global_accept_enable_r  <= `NIA_RST_ENABLE;
      current_service_level_r <= `NIA_RST_LEVEL;
    end else if (trap_c) begin
      global_accept_enable_r  <= 1'b0;
      current_service_level_r <= 1'b1;
    end else if (take_c) begin
      global_accept_enable_r  <= 1'b0;
      current_service_level_r <= urgency_select_bit_r[win_c];
    end else if (INSTR_I.instr_end && INSTR_I.return_op) begin
      global_accept_enable_r  <= RESTORE_STATE_I.global_accept_enable;
      current_service_level_r <= RESTORE_STATE_I.current_service_level;
    end else if (INSTR_I.instr_end && INSTR_I.accept_on_instruction) begin
      global_accept_enable_r  <= 1'b1;
    end else if (INSTR_I.instr_end && INSTR_I.accept_off_instruction) begin
      global_accept_enable_r  <= 1'b0;
    end else if (wr_c && hit_st_c) begin
      global_accept_enable_r  <= PWDATA_I[`NIA_STATE_ENABLE_BIT];
      current_service_level_r <= PWDATA_I[`NIA_STATE_LEVEL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // result to the core, one-cycle pulse with the word to stack
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ACCEPT_O      <= 1'b0;
      ACCEPT_SOFT_O <= 1'b0;
      ACCEPT_SRC_O  <= '0;
      STACK_STATE_O <= '0;
    end else begin
      ACCEPT_O      <= take_c || trap_c;
      ACCEPT_SOFT_O <= trap_c;
      if (take_c || trap_c) begin
        ACCEPT_SRC_O  <= take_c ? win_c : '0;
        // status word before the change; core stacks it, then the pc
        STACK_STATE_O <= '{global_accept_enable:  global_accept_enable_r,
                           current_service_level: current_service_level_r};
      end
    end
  end

  assign STATE_O = '{global_accept_enable:  global_accept_enable_r,
                     current_service_level: current_service_level_r};

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);

  no_accept_disabled_a: assert property (ACCEPT_O && !ACCEPT_SOFT_O
      |-> $past(global_accept_enable_r)) else $error("accepted while disabled");
  clear_enable_a: assert property (ACCEPT_O |-> !global_accept_enable_r)
      else $error("enable not cleared on accept");
  level_copy_a: assert property (ACCEPT_O && !ACCEPT_SOFT_O
      |-> current_service_level_r == $past(urgency_select_bit_r[win_c]))
      else $error("service level not copied");
  low_refused_a: assert property (take_c && !current_service_level_r
      |-> !urgency_select_bit_r[win_c]) else $error("low urgency nested");
  hold_defer_a: assert property (INSTR_I.instr_end && INSTR_I.hold_class
      |=> !ACCEPT_O || ACCEPT_SOFT_O) else $error("accepted after hold op");
  flag_defer_a: assert property (flag_touch_c |-> !take_c)
      else $error("accepted during flag write");
  trap_always_a: assert property (trap_c |=> ACCEPT_O && ACCEPT_SOFT_O)
      else $error("trap not accepted");
  trap_no_mask_a: assert property (trap_c |-> !take_c)
      else $error("maskable taken at trap");
  // a new capture may add bits, but no refused eligible bit may vanish
  pending_kept_a: assert property (eligible_c != '0 && !global_accept_enable_r
      && !wr_c |=> (pending_request_bit_r & $past(eligible_c)) == $past(eligible_c))
      else $error("refused request lost");
  urgency_wins_a: assert property (take_c && high_c != '0
      |-> !urgency_select_bit_r[win_c]) else $error("low urgency beat high");
  capture_a: assert property (SRC_REQ_I[0] |=> pending_request_bit_r[0])
      else $error("request not captured");
  only_boundary_a: assert property (ACCEPT_O |-> $past(INSTR_I.instr_end))
      else $error("accept off boundary");
  // trap service: enable off, both levels admitted, no source index
  trap_level_a: assert property (ACCEPT_SOFT_O
      |-> current_service_level_r && !global_accept_enable_r) else $error("trap state wrong");
  trap_source_a: assert property (ACCEPT_SOFT_O |-> ACCEPT_SRC_O == '0)
      else $error("trap reported a source");

  // main scenarios: nesting, trap service, flag write at an end, chained hold
  nested_high_c: cover property (take_c && !current_service_level_r);
  nested_any_c:  cover property (take_c ##[1:20] take_c);
  trap_then_c:   cover property (trap_c ##[1:20] take_c);
  flag_defer_c:  cover property (flag_touch_c && INSTR_I.instr_end);
  chained_hold_c: cover property ((INSTR_I.instr_end && INSTR_I.hold_class)
      ##2 (INSTR_I.instr_end && INSTR_I.hold_class));

endmodule

`default_nettype wire

/* nia_core_model.sv */
// nia_core_model.sv: core-side partner that keeps the status-word stack.
// assumes: same clock as the block; each return op pops one pushed word.
`timescale 1ns/100ps
`default_nettype none

module nia_core_model (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // acceptance and instruction reports
  input  wire logic                accept_i,
  input  wire nia_pkg::nia_state_t stack_state_i,
  input  wire nia_pkg::nia_instr_t instr_i,
  // word popped by a return op
  output nia_pkg::nia_state_t      restore_o
);
  logic [1:0] stk_r [8];
  logic [2:0] sp_r;

  // ----------------------------------------------------------------------
  // stack
  // ----------------------------------------------------------------------
  // push on acceptance, pop on return; depth wraps at 8, no deeper nesting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_r  <= 3'h0;
      stk_r <= '{default: 2'h0};
    end else if (accept_i) begin
      stk_r[sp_r] <= stack_state_i;
      sp_r        <= sp_r + 3'h1;
    end else if (instr_i.instr_end && instr_i.return_op) begin
      sp_r <= sp_r - 3'h1;
    end
  end

  // top word stands ready for whenever a return op ends
  assign restore_o = nia_pkg::nia_state_t'(stk_r[sp_r - 3'h1]);
endmodule

`default_nettype wire

/* tb_top.sv */
// tb_top.sv: self-checking bench for the nested interrupt acceptance block.
// assumes: nia_pkg, nia_accept and nia_core_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "nia_defines.svh"

module tb_top;
  typedef struct packed {
    logic [7:0] blk;
    logic [7:0] urg;
    logic [7:0] req;
    logic [1:0] st;
    logic       hold;
    logic       acc;
    logic [2:0] src;
    logic       lvl;
  } nia_row_t;

  // instruction kinds: end, hold, trap, on, off, return
  localparam logic [5:0]  I_NORM  = 6'h20;
  localparam logic [5:0]  I_HOLD  = 6'h30;
  localparam logic [5:0]  I_TRAP  = 6'h28;
  localparam logic [5:0]  I_ON    = 6'h34;
  localparam logic [5:0]  I_OFF   = 6'h32;
  localparam logic [5:0]  I_RET   = 6'h31;
  localparam logic [31:0] RSTV[4] = '{32'h0, 32'hff, 32'hff, 32'h2};
  localparam logic [31:0] ROWS[8] = '{32'h00ff0cd5, 32'h00f70cd6, 32'h00ff1040, 32'h00ef1058,
                                      32'h00ff0180, 32'h00ff01e0, 32'h01ff01c0, 32'h00bf415c};

  logic                clk_sys, arst_n, psel, penable, pwrite, acc_s, soft_s, err_s;
  logic                pready, pslverr, accept, accept_soft;
  logic [7:0]          paddr, src_req;
  logic [31:0]         pwdata, prdata, rd_s;
  logic [2:0]          accept_src;
  nia_pkg::nia_instr_t instr;
  nia_pkg::nia_state_t restore, stack_state, state;
  nia_row_t            r;
  int                  errors, checked;

  nia_accept #(.NUM_SRC(8)) i_nia_accept (
    .CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .INSTR_I(instr), .RESTORE_STATE_I(restore),
    .SRC_REQ_I(src_req), .ACCEPT_O(accept), .ACCEPT_SOFT_O(accept_soft),
    .ACCEPT_SRC_O(accept_src), .STACK_STATE_O(stack_state), .STATE_O(state));

  nia_core_model i_nia_core_model (
    .clk_i(clk_sys), .arst_n_i(arst_n), .accept_i(accept), .stack_state_i(stack_state),
    .instr_i(instr), .restore_o(restore));

  // ----------------------------------------------------------------------
  // clock, watchdog and tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // the run needs about 220 cycles; about thirty times that means a hang
  initial begin
    #28000;
    errors++;
    test_done();
  end

  task automatic test_done;
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer; waits for pready, the watchdog bounds a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd_s    = prdata;
    err_s   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one instruction end, then the acceptance answer one cycle later
  task automatic step(input logic [5:0] k, input logic ea, input logic [1:0] es);
    @(posedge clk_sys);
    instr <= nia_pkg::nia_instr_t'(k);
    @(posedge clk_sys);
    instr <= '0;
    #1;
    acc_s  = accept;
    soft_s = accept_soft;
    cmp_bit("accept", ea, acc_s);
    cmp_word("state", {30'h0, es}, 32'(state));
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_sys);
    src_req <= m;
    @(posedge clk_sys);
    src_req <= 8'h00;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, src_req} = '0;
    instr = '0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      cmp_word("reset read", RSTV[i], rd_s);
    end
    apb(1'b0, 8'h10, 32'h0);
    cmp_bit("slverr", 1'b1, err_s);
    // table rows: flags set, one instruction, answer and pending left over
    for (int i = 0; i < 8; i++) begin
      r = nia_row_t'(ROWS[i]);
      apb(1'b1, `NIA_OFS_BLOCK, {24'h0, r.blk});
      apb(1'b1, `NIA_OFS_URGENCY, {24'h0, r.urg});
      apb(1'b1, `NIA_OFS_REQ, {24'h0, r.req});
      apb(1'b1, `NIA_OFS_STATE, {30'h0, r.st});
      step(r.hold ? I_HOLD : I_NORM, r.acc, r.acc ? {1'b0, r.lvl} : {r.st[0], r.st[1]});
      if (r.acc)
        cmp_word("source", 32'(r.src), 32'(accept_src));
      apb(1'b0, `NIA_OFS_REQ, 32'h0);
      cmp_word("pending", {24'h0, r.req & ~(r.acc ? 8'h1 << r.src : 8'h0)}, rd_s);
    end
    // nesting walk: urgent service, low request refused, return, chained hold
    apb(1'b1, `NIA_OFS_URGENCY, 32'hfe);
    apb(1'b1, `NIA_OFS_STATE, 32'h3);
    pulse(8'h21);
    apb(1'b0, `NIA_OFS_REQ, 32'h0);
    cmp_word("captured", 32'h21, rd_s);
    step(I_NORM, 1'b1, 2'b00);
    cmp_word("source", 32'h0, 32'(accept_src));
    cmp_word("stacked", 32'h3, 32'(stack_state));
    step(I_NORM, 1'b0, 2'b00);
    step(I_ON, 1'b0, 2'b10);
    step(I_NORM, 1'b0, 2'b10);
    step(I_RET, 1'b0, 2'b11);
    step(I_HOLD, 1'b0, 2'b11);
    step(I_NORM, 1'b1, 2'b01);
    cmp_word("source", 32'h5, 32'(accept_src));
    // trap beats a ready maskable request; a low-urgency one nests inside it
    apb(1'b1, `NIA_OFS_URGENCY, 32'hff);
    apb(1'b1, `NIA_OFS_STATE, 32'h3);
    step(I_OFF, 1'b0, 2'b01);
    pulse(8'h02);
    apb(1'b1, `NIA_OFS_STATE, 32'h3);
    step(I_TRAP, 1'b1, 2'b01);
    cmp_bit("trap", 1'b1, soft_s);
    cmp_word("source", 32'h0, 32'(accept_src));
    step(I_ON, 1'b0, 2'b11);
    step(I_NORM, 1'b1, 2'b01);
    cmp_word("source", 32'h1, 32'(accept_src));
    // flag write landing on an instruction end defers acceptance by one end
    pulse(8'h04);
    apb(1'b1, `NIA_OFS_STATE, 32'h3);
    fork
      apb(1'b1, `NIA_OFS_URGENCY, 32'hff);
      begin
        @(posedge clk_sys);
        step(I_NORM, 1'b0, 2'b11);
      end
    join
    step(I_NORM, 1'b1, 2'b01);
    cmp_word("source", 32'h2, 32'(accept_src));
    // mid-run reset brings every flag back to its reset value
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    cmp_word("state", 32'h1, 32'(state));
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      cmp_word("reset read", RSTV[i], rd_s);
    end
    test_done();
  end
endmodule

`default_nettype wire
